// file: hdl/bfd_pkg.sv
package bfd_pkg;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_ENABLE      = 8'h10;
    localparam logic [7:0] ADDR_BRT_CTRL    = 8'h11;
    localparam logic [7:0] ADDR_BOOST_CTRL  = 8'h13;
    localparam logic [7:0] ADDR_UPPER_LIM   = 8'h15;
    localparam logic [7:0] ADDR_LOWER_LIM   = 8'h16;
    localparam logic [7:0] ADDR_REDUCE_CEIL = 8'h17;
    localparam logic [7:0] ADDR_BRT_LOW     = 8'h18;
    localparam logic [7:0] ADDR_BRT_HIGH    = 8'h19;
    localparam logic [7:0] ADDR_FAULT_CTRL  = 8'h1e;
    localparam logic [7:0] ADDR_FAULT_FLAGS = 8'h1f;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_DEV_EN     = 0;
    localparam int BIT_REDUCE_POL = 0;
    localparam int BIT_FREQ_SEL   = 5;
    localparam int BIT_FREQ_SHIFT = 6;
    localparam int BIT_OVP_LO     = 2;
    localparam int BIT_OVP_SD_EN  = 0;
    localparam int BIT_OVP_FLAG   = 0;
    localparam int BIT_OPEN_FLAG  = 4;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_ENABLE  = 8'h07;
    localparam logic [7:0] RST_ZERO    = 8'h00;
    localparam logic [7:0] RST_BRT_HI  = 8'hff;
    localparam logic [2:0] RST_BRT_LO  = 3'h7;

    // ------------------------------------------------------------------
    // Frequency and timing
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {BFD_F250K, BFD_F500K, BFD_F1M} bfd_freq_t;
    localparam int CLK_MHZ        = 100;
    localparam int OVP_PERSIST_US = 1000;
    localparam int OVP_PERSIST_CYC = OVP_PERSIST_US * CLK_MHZ;
    localparam int OPEN_HITS      = 3;
endpackage

// file: hdl/bfd_freq_sel.sv
`timescale 1ns/1ps
// Picks switching frequency from brightness high byte and limits
module bfd_freq_sel
(
    input  wire logic [7:0] brt_high_i,   // Brightness high byte
    input  wire logic [7:0] upper_lim_i,  // Upper limit
    input  wire logic [7:0] lower_lim_i,  // Lower limit
    input  wire logic       freq_sel_i,   // Programmed 1 MHz select
    output logic      [1:0] freq_o,       // Selected frequency code
    output logic            auto_o        // Automatic mode active
);
    // Auto mode when any limit is non-zero
    assign auto_o = (upper_lim_i != 8'h00) || (lower_lim_i != 8'h00);
    // Band decision, equality with lower limit is middle band
    wire logic below_low = brt_high_i < lower_lim_i;
    wire logic at_high   = brt_high_i >= upper_lim_i;
    wire logic [1:0] prog_f = freq_sel_i ? bfd_pkg::BFD_F1M
                                         : bfd_pkg::BFD_F500K;
    wire logic [1:0] auto_f = at_high ? bfd_pkg::BFD_F1M :
                              below_low ? bfd_pkg::BFD_F250K :
                              bfd_pkg::BFD_F500K;
    assign freq_o = auto_o ? auto_f : prog_f;
endmodule

// file: hdl/bfd_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - 250 kHz only in auto, 50% duty
// - Compare limits with brightness high byte
// - Below lower limit selects 250 kHz
// - At/above upper 1 MHz, else 500
// - Auto active when either limit non-zero
// - Auto off uses programmed frequency bit
// - Reduce gives ceiling byte, low bits zero
// - Reduce only lowers the current
// - Reduced target applied within 50 us
// - Release restores original brightness target
// - Ceiling byte register at 0x17
// - Polarity bit selects active reduce level
// - Two-bit field picks overvoltage threshold
// - Overvoltage halts switching until hysteresis clears
// - Overvoltage over 1 ms sets flag
// - Three open hits set both flags
// - Long overvoltage with open sink sets both
// - Shutdown enable bit gates fault shutdown
// - Re-enable refused until flags read
// - Code updates on high byte write
// - Bit 5 frequency, bit 6 shift
module bfd_ctrl
#(
    parameter int OVP_PERSIST_CYC = bfd_pkg::OVP_PERSIST_CYC
)
(
    input  wire logic        clk_sys_i,       // System clock 100 MHz
    input  wire logic        rst_b_i,         // Async reset, active low
    input  wire logic        reg_wr_i,        // Register write strobe
    input  wire logic        reg_rd_i,        // Register read strobe
    input  wire logic [7:0]  reg_addr_i,      // Register address
    input  wire logic [7:0]  reg_wdata_i,     // Register write data
    output logic      [7:0]  reg_rdata_o,     // Register read data
    input  wire logic        backlight_reduce_input_i, // Reduce pin
    input  wire logic [10:0] src_code_i,      // PWM-derived code
    input  wire logic        use_pwm_i,       // Take code from PWM path
    input  wire logic        ovp_above_i,     // Output above threshold
    input  wire logic        ovp_below_hyst_i,// Output below hysteresis
    input  wire logic        sink_one_low_i,  // Sink one at/below 40 mV
    input  wire logic        sink_two_low_i,  // Sink two at/below 40 mV
    output logic      [10:0] brightness_code_o, // Code to mapper
    output logic      [1:0]  freq_o,          // Frequency code
    output logic             freq_shift_o,    // 12 percent shift down
    output logic             duty_limit_o,    // 50 percent duty cap
    output logic             boost_run_o,     // Boost switching allowed
    output logic      [1:0]  ovp_level_o,     // Overvoltage threshold sel
    output logic             device_on_o      // Device enabled
);
    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [7:0]  enable_r;
    logic [7:0]  brt_ctrl_r;
    logic [7:0]  boost_ctrl_r;
    logic [7:0]  upper_lim_r;
    logic [7:0]  lower_lim_r;
    logic [7:0]  reduce_ceil_r;
    logic [2:0]  brt_low_r;
    logic [7:0]  brt_high_r;
    logic [10:0] brt_code_r;
    logic [7:0]  fault_ctrl_r;
    logic        ovp_flag_r;
    logic        open_flag_r;
    logic        lockout_r;
    logic [31:0] persist_r;
    logic [1:0]  hits_r;
    logic        above_d_r;
    logic        boost_hold_r;
    logic [7:0]  rdata_r;
    logic [10:0] out_code_r;
    logic [1:0]  freq_r;
    logic        shift_r;
    logic        duty_r;
    logic        run_r;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire logic wr_en    = reg_wr_i && reg_addr_i == bfd_pkg::ADDR_ENABLE;
    wire logic wr_bctl  = reg_wr_i && reg_addr_i == bfd_pkg::ADDR_BRT_CTRL;
    wire logic wr_boost = reg_wr_i &&
                          reg_addr_i == bfd_pkg::ADDR_BOOST_CTRL;
    wire logic wr_up    = reg_wr_i && reg_addr_i == bfd_pkg::ADDR_UPPER_LIM;
    wire logic wr_lo    = reg_wr_i && reg_addr_i == bfd_pkg::ADDR_LOWER_LIM;
    wire logic wr_ceil  = reg_wr_i &&
                          reg_addr_i == bfd_pkg::ADDR_REDUCE_CEIL;
    wire logic wr_bl    = reg_wr_i && reg_addr_i == bfd_pkg::ADDR_BRT_LOW;
    wire logic wr_bh    = reg_wr_i && reg_addr_i == bfd_pkg::ADDR_BRT_HIGH;
    wire logic wr_fc    = reg_wr_i &&
                          reg_addr_i == bfd_pkg::ADDR_FAULT_CTRL;
    wire logic rd_flags = reg_rd_i &&
                          reg_addr_i == bfd_pkg::ADDR_FAULT_FLAGS;

    // ------------------------------------------------------------------
    // Fault conditions
    // ------------------------------------------------------------------
    // Only enabled sinks count toward an open string
    wire logic sink_low = (enable_r[1] && sink_one_low_i) ||
                          (enable_r[2] && sink_two_low_i);
    wire logic above_rise = ovp_above_i && !above_d_r;
    wire logic persist_done =
        persist_r >= 32'(OVP_PERSIST_CYC);
    wire logic open_hit3 = above_rise && sink_low &&
        hits_r == 2'(bfd_pkg::OPEN_HITS - 1);
    wire logic set_ovp  = persist_done || open_hit3;
    wire logic set_open = open_hit3 ||
                          (persist_done && sink_low);
    wire logic sd_en    = fault_ctrl_r[bfd_pkg::BIT_OVP_SD_EN];
    wire logic trip     = set_ovp && sd_en;
    // Enable write blocked while lockout stands
    wire logic en_ok    = wr_en && (!lockout_r || rd_flags);

    // ------------------------------------------------------------------
    // Brightness path
    // ------------------------------------------------------------------
    wire logic [10:0] target = use_pwm_i ? src_code_i : brt_code_r;
    wire logic reduce_on = backlight_reduce_input_i ^
        brt_ctrl_r[bfd_pkg::BIT_REDUCE_POL];
    wire logic [10:0] reduced = {reduce_ceil_r, 3'h0};
    wire logic [10:0] eff_code =
        (reduce_on && reduced < target) ? reduced
                                        : target;

    // ------------------------------------------------------------------
    // Frequency selection
    // ------------------------------------------------------------------
    logic [1:0] sel_f;
    logic       auto_on;
    bfd_freq_sel u_freq
    (
        .brt_high_i  (eff_code[10:3]),
        .upper_lim_i (upper_lim_r),
        .lower_lim_i (lower_lim_r),
        .freq_sel_i  (boost_ctrl_r[bfd_pkg::BIT_FREQ_SEL]),
        .freq_o      (sel_f),
        .auto_o      (auto_on)
    );
    wire logic is_250 = auto_on && sel_f == bfd_pkg::BFD_F250K;

    // ------------------------------------------------------------------
    // Read mux; reserved and unmapped read zero
    // ------------------------------------------------------------------
    wire logic [7:0] flags_v = {3'h0, open_flag_r, 3'h0, ovp_flag_r};
    wire logic [7:0] rd_mux =
        reg_addr_i == bfd_pkg::ADDR_ENABLE      ? enable_r :
        reg_addr_i == bfd_pkg::ADDR_BRT_CTRL    ? brt_ctrl_r :
        reg_addr_i == bfd_pkg::ADDR_BOOST_CTRL  ? boost_ctrl_r :
        reg_addr_i == bfd_pkg::ADDR_UPPER_LIM   ? upper_lim_r :
        reg_addr_i == bfd_pkg::ADDR_LOWER_LIM   ? lower_lim_r :
        reg_addr_i == bfd_pkg::ADDR_REDUCE_CEIL ? reduce_ceil_r :
        reg_addr_i == bfd_pkg::ADDR_BRT_LOW     ? {5'h0, brt_low_r} :
        reg_addr_i == bfd_pkg::ADDR_BRT_HIGH    ? brt_high_r :
        reg_addr_i == bfd_pkg::ADDR_FAULT_CTRL  ? fault_ctrl_r :
        reg_addr_i == bfd_pkg::ADDR_FAULT_FLAGS ? flags_v : 8'h00;

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            brt_ctrl_r    <= bfd_pkg::RST_ZERO;
            boost_ctrl_r  <= bfd_pkg::RST_ZERO;
            upper_lim_r   <= bfd_pkg::RST_ZERO;
            lower_lim_r   <= bfd_pkg::RST_ZERO;
            reduce_ceil_r <= bfd_pkg::RST_ZERO;
            brt_low_r     <= bfd_pkg::RST_BRT_LO;
            brt_high_r    <= bfd_pkg::RST_BRT_HI;
            fault_ctrl_r  <= bfd_pkg::RST_ZERO;
        end
        else
        begin
            if (wr_bctl)  brt_ctrl_r    <= reg_wdata_i;
            if (wr_boost) boost_ctrl_r  <= reg_wdata_i;
            if (wr_up)    upper_lim_r   <= reg_wdata_i;
            if (wr_lo)    lower_lim_r   <= reg_wdata_i;
            if (wr_ceil)  reduce_ceil_r <= reg_wdata_i;
            if (wr_bl)    brt_low_r     <= reg_wdata_i[2:0];
            if (wr_bh)    brt_high_r    <= reg_wdata_i;
            if (wr_fc)    fault_ctrl_r  <= reg_wdata_i;
        end
    end

    // ------------------------------------------------------------------
    // Code in effect loads on high byte write only
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            brt_code_r <= {bfd_pkg::RST_BRT_HI, bfd_pkg::RST_BRT_LO};
        else if (wr_bh)
            brt_code_r <= {reg_wdata_i, brt_low_r};
    end

    // ------------------------------------------------------------------
    // Enable register with fault shutdown
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            enable_r <= bfd_pkg::RST_ENABLE;
        else if (trip)
            enable_r[bfd_pkg::BIT_DEV_EN] <= 1'b0;
        else if (en_ok)
            enable_r <= {5'h0, reg_wdata_i[2:0]};
    end

    // ------------------------------------------------------------------
    // Lockout after shutdown until flags read
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            lockout_r <= 1'b0;
        else if (trip)
            lockout_r <= 1'b1;
        else if (rd_flags)
            lockout_r <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Fault flags, set wins over read clear
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ovp_flag_r  <= 1'b0;
            open_flag_r <= 1'b0;
        end
        else
        begin
            ovp_flag_r  <= set_ovp  || (ovp_flag_r  && !rd_flags);
            open_flag_r <= set_open || (open_flag_r && !rd_flags);
        end
    end

    // ------------------------------------------------------------------
    // Overvoltage persistence timer and open hit counter
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            persist_r <= 32'h0;
            hits_r    <= 2'h0;
            above_d_r <= 1'b0;
        end
        else
        begin
            above_d_r <= ovp_above_i;
            if (!ovp_above_i || persist_done)
                persist_r <= 32'h0;
            else
                persist_r <= persist_r + 32'h1;
            if (open_hit3 || !enable_r[bfd_pkg::BIT_DEV_EN])
                hits_r <= 2'h0;
            else if (above_rise && sink_low)
                hits_r <= hits_r + 2'h1;
        end
    end

    // ------------------------------------------------------------------
    // Boost hold on excursion until below hysteresis
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            boost_hold_r <= 1'b0;
        else if (ovp_above_i)
            boost_hold_r <= 1'b1;
        else if (ovp_below_hyst_i)
            boost_hold_r <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Registered outputs; reduce takes effect next cycle
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            out_code_r <= 11'h0;
            freq_r     <= bfd_pkg::BFD_F500K;
            shift_r    <= 1'b0;
            duty_r     <= 1'b0;
            run_r      <= 1'b0;
            rdata_r    <= 8'h00;
        end
        else
        begin
            out_code_r <= eff_code;
            freq_r     <= sel_f;
            shift_r    <= boost_ctrl_r[bfd_pkg::BIT_FREQ_SHIFT];
            duty_r     <= is_250;
            run_r      <= enable_r[bfd_pkg::BIT_DEV_EN] &&
                          !boost_hold_r && !ovp_above_i;
            rdata_r    <= rd_mux;
        end
    end

    assign brightness_code_o = out_code_r;
    assign freq_o            = freq_r;
    assign freq_shift_o      = shift_r;
    assign duty_limit_o      = duty_r;
    assign boost_run_o       = run_r;
    assign ovp_level_o       = boost_ctrl_r[bfd_pkg::BIT_OVP_LO +: 2];
    assign device_on_o       = enable_r[bfd_pkg::BIT_DEV_EN];
    assign reg_rdata_o       = rdata_r;
endmodule

// file: dv/bfd_ctrl_sva.sv
`timescale 1ns/1ps
// Port checks of frequency, reduce and fault logic
module bfd_ctrl_sva
#(
    parameter int OVP_PERSIST_CYC = bfd_pkg::OVP_PERSIST_CYC
)
(
    input  wire logic        clk_sys_i,                // Clock
    input  wire logic        rst_b_i,                  // Reset
    input  wire logic        reg_wr_i,                 // Write
    input  wire logic        reg_rd_i,                 // Read
    input  wire logic [7:0]  reg_addr_i,               // Address
    input  wire logic [7:0]  reg_wdata_i,              // Write data
    input  wire logic        backlight_reduce_input_i, // Reduce pin
    input  wire logic        ovp_above_i,              // Above level
    input  wire logic        ovp_below_hyst_i,         // Below hysteresis
    input  wire logic [10:0] brightness_code_o,        // Code
    input  wire logic [1:0]  freq_o,                   // Frequency
    input  wire logic        duty_limit_o,             // Duty cap
    input  wire logic        boost_run_o,              // Switching on
    input  wire logic [1:0]  ovp_level_o,              // Threshold sel
    input  wire logic        device_on_o               // Enabled
);
    logic [7:0]  ceil_r;
    logic        pol_r, sd_r, lock_r;
    logic        on_q, wr10_q, act, wr10;
    logic [31:0] hi_cnt;

    // Decodes used by the shadow state and the reduce sequence
    assign wr10 = reg_wr_i && reg_addr_i == 8'h10;
    assign act  = backlight_reduce_input_i ^ pol_r;

    // Shadow control bits, lockout, above-level run length
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ceil_r <= 8'h00;
            pol_r  <= 1'b0;
            sd_r   <= 1'b0;
            lock_r <= 1'b0;
            on_q   <= 1'b1;
            wr10_q <= 1'b0;
            hi_cnt <= 32'h0;
        end
        else
        begin
            if (reg_wr_i && reg_addr_i == 8'h17)
                ceil_r <= reg_wdata_i;
            if (reg_wr_i && reg_addr_i == 8'h11)
                pol_r <= reg_wdata_i[0];
            if (reg_wr_i && reg_addr_i == 8'h1e)
                sd_r <= reg_wdata_i[0];
            if (reg_rd_i && reg_addr_i == 8'h1f)
                lock_r <= 1'b0;
            else if (on_q && !device_on_o && !wr10_q)
                lock_r <= 1'b1;
            on_q   <= device_on_o;
            wr10_q <= wr10;
            hi_cnt <= ovp_above_i ? hi_cnt + 32'h1 : 32'h0;
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence s_reduce_held;
        (act && !reg_wr_i) [*3];
    endsequence
    sequence s_calm;
        (ovp_below_hyst_i && !ovp_above_i && device_on_o) [*3];
    endsequence

    AST_DUTY_CAP: assert property (
        duty_limit_o == (freq_o == bfd_pkg::BFD_F250K))
        else $error("duty cap wrong");
    AST_FREQ_CODE: assert property (freq_o != 2'h3)
        else $error("bad frequency code");
    AST_LEVEL: assert property (
        reg_wr_i && reg_addr_i == 8'h13 |=>
        ovp_level_o == $past(reg_wdata_i[3:2]))
        else $error("threshold not taken");
    AST_HALT: assert property (
        $rose(ovp_above_i) |-> ##[1:2] !boost_run_o)
        else $error("switching not stopped");
    AST_HOLD_OFF: assert property (
        !boost_run_o && !ovp_below_hyst_i |=> !boost_run_o)
        else $error("resumed in hysteresis");
    AST_RESUME: assert property (s_calm |-> boost_run_o)
        else $error("switching not resumed");
    AST_REDUCE: assert property (
        s_reduce_held |-> brightness_code_o <= {ceil_r, 3'h0})
        else $error("code above ceiling");
    AST_LOCKOUT: assert property (lock_r |-> !device_on_o)
        else $error("enabled while locked");
    AST_TRIP_CAUSE: assert property (
        $fell(device_on_o) |-> sd_r || $past(wr10))
        else $error("shutdown without cause");
    AST_PERSIST: assert property (
        sd_r && hi_cnt > OVP_PERSIST_CYC + 2 |-> !device_on_o)
        else $error("no overvoltage trip");
endmodule

bind bfd_ctrl bfd_ctrl_sva #(.OVP_PERSIST_CYC(OVP_PERSIST_CYC)) i_sva
(
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .backlight_reduce_input_i(backlight_reduce_input_i),
    .ovp_above_i(ovp_above_i), .ovp_below_hyst_i(ovp_below_hyst_i),
    .brightness_code_o(brightness_code_o), .freq_o(freq_o),
    .duty_limit_o(duty_limit_o), .boost_run_o(boost_run_o),
    .ovp_level_o(ovp_level_o), .device_on_o(device_on_o)
);

// file: dv/bfd_sense_model.sv
`timescale 1ns/1ps
// Reduce pin and boost-stage comparators seen by the block
module bfd_sense_model
(
    input  wire logic clk_sys_i,      // System clock
    output logic      reduce_o,       // Reduce pin level
    output logic      above_o,        // Output above threshold
    output logic      below_hyst_o,   // Output below hysteresis
    output logic      sink_one_low_o, // Sink one starved
    output logic      sink_two_low_o  // Sink two starved
);
    // Quiet start: output regulated, sinks healthy
    initial
    begin
        reduce_o       = 1'b0;
        above_o        = 1'b0;
        below_hyst_o   = 1'b1;
        sink_one_low_o = 1'b0;
        sink_two_low_o = 1'b0;
    end

    // Pin moves off the sampling edge
    task automatic set_pin(input logic lvl);
        @(negedge clk_sys_i);
        reduce_o = lvl;
    endtask

    // Above threshold is never below hysteresis
    task automatic set_sense(input logic a, input logic b,
                             input logic [1:0] open);
        @(negedge clk_sys_i);
        above_o        = a;
        below_hyst_o   = b && !a;
        sink_one_low_o = open[0];
        sink_two_low_o = open[1];
    endtask
endmodule

// file: dv/tb_boost_freq_dim_fault_ctrl.sv
`timescale 1ns/1ps
`define CHK(g, e) check_val(32'(g), 32'(e))
module tb_boost_freq_dim_fault_ctrl;
    localparam int PER = 50;
    logic        clk_sys_i   = 1'b0;
    logic        rst_b_i     = 1'b0;
    logic        reg_wr_i    = 1'b0;
    logic        reg_rd_i    = 1'b0;
    logic [7:0]  reg_addr_i, reg_wdata_i;
    logic [10:0] src_code_i;
    logic        use_pwm_i   = 1'b0;
    logic [7:0]  reg_rdata_o;
    logic        pin, above, below, s1, s2;
    logic [10:0] brightness_code_o;
    logic [1:0]  freq_o, ovp_level_o;
    logic        freq_shift_o, duty_limit_o, boost_run_o, device_on_o;
    int          failures     = 0;
    int          total_checks = 0;
    logic [7:0]  ra [8] = '{8'h10, 8'h18, 8'h19, 8'h15,
                            8'h16, 8'h17, 8'h1f, 8'h3a};
    logic [7:0]  rv [8] = '{8'h07, 8'h07, 8'hff, 8'h00,
                            8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0]  bh [5] = '{8'h2e, 8'h2f, 8'h7f, 8'h80, 8'hff};
    logic [1:0]  bf [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2};

    bfd_ctrl #(.OVP_PERSIST_CYC(PER)) i_dut
    (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .backlight_reduce_input_i(pin),
        .src_code_i(src_code_i), .use_pwm_i(use_pwm_i),
        .ovp_above_i(above), .ovp_below_hyst_i(below),
        .sink_one_low_i(s1), .sink_two_low_i(s2),
        .brightness_code_o(brightness_code_o), .freq_o(freq_o),
        .freq_shift_o(freq_shift_o), .duty_limit_o(duty_limit_o),
        .boost_run_o(boost_run_o), .ovp_level_o(ovp_level_o),
        .device_on_o(device_on_o)
    );

    bfd_sense_model i_model
    (
        .clk_sys_i(clk_sys_i), .reduce_o(pin), .above_o(above),
        .below_hyst_o(below), .sink_one_low_o(s1), .sink_two_low_o(s2)
    );

    // 100 MHz clock
    initial
    begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task automatic check_val(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            failures++;
            $display("unexpected at %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk_sys_i);
        reg_addr_i  = a;
        reg_wdata_i = v;
        reg_wr_i    = 1'b1;
        @(negedge clk_sys_i);
        reg_wr_i = 1'b0;
        tick(3);
    endtask

    // Read and compare registered data
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_sys_i);
        reg_addr_i = a;
        reg_rd_i   = 1'b1;
        @(negedge clk_sys_i);
        reg_rd_i = 1'b0;
        `CHK(reg_rdata_o, e);
    endtask

    // High byte write loads the code
    task automatic brightness_code(input logic [7:0] hi, input logic [2:0] lo);
        wr(8'h18, {5'h00, lo});
        wr(8'h19, hi);
    endtask

    task automatic pchk(input logic l, input logic [10:0] e);
        i_model.set_pin(l);
        tick(3);
        `CHK(brightness_code_o, e);
    endtask

    task automatic schk(input logic a, input logic b, input logic e);
        i_model.set_sense(a, b, 2'b00);
        tick(3);
        `CHK(boost_run_o, e);
    endtask

    task automatic finish_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        tick(12);
        rst_b_i = 1'b1;
        tick(2);
        foreach (ra[i]) rdc(ra[i], rv[i]);
        `CHK(brightness_code_o, 11'h7ff);
        `CHK(freq_o, bfd_pkg::BFD_F500K);
        $display("test reset done");
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h13, 8'h60 | 8'(i << 2));
            `CHK(ovp_level_o, i);
            `CHK({freq_shift_o, freq_o}, 3'h6);
        end
        wr(8'h13, 8'h00);
        `CHK({freq_shift_o, freq_o}, 3'h1);
        $display("test programmed done");
        wr(8'h15, 8'h80);
        wr(8'h16, 8'h2f);
        foreach (bh[i])
        begin
            brightness_code(bh[i], 3'h0);
            `CHK(freq_o, bf[i]);
            `CHK(duty_limit_o, bf[i] == 2'h0);
        end
        wr(8'h18, 8'h05);
        `CHK(brightness_code_o, 11'h7f8);
        wr(8'h19, 8'h10);
        `CHK(brightness_code_o, 11'h085);
        wr(8'h13, 8'h20);
        wr(8'h16, 8'h00);
        `CHK(freq_o, bfd_pkg::BFD_F500K);
        wr(8'h15, 8'h00);
        `CHK(freq_o, bfd_pkg::BFD_F1M);
        $display("test auto done");
        wr(8'h17, 8'h40);
        brightness_code(8'h80, 3'h5);
        pchk(1'b1, 11'h200);
        pchk(1'b0, 11'h405);
        brightness_code(8'h30, 3'h5);
        pchk(1'b1, 11'h185);
        i_model.set_pin(1'b0);
        brightness_code(8'h80, 3'h5);
        wr(8'h11, 8'h01);
        `CHK(brightness_code_o, 11'h200);
        pchk(1'b1, 11'h405);
        wr(8'h11, 8'h00);
        use_pwm_i  = 1'b1;
        src_code_i = 11'h654;
        pchk(1'b0, 11'h654);
        pchk(1'b1, 11'h200);
        i_model.set_pin(1'b0);
        use_pwm_i = 1'b0;
        $display("test reduce done");
        wr(8'h13, 8'h08);
        schk(1'b1, 1'b0, 1'b0);
        schk(1'b0, 1'b0, 1'b0);
        schk(1'b0, 1'b1, 1'b1);
        i_model.set_sense(1'b1, 1'b0, 2'b00);
        tick(PER - 12);
        rdc(8'h1f, 8'h00);
        tick(15);
        i_model.set_sense(1'b0, 1'b1, 2'b00);
        rdc(8'h1f, 8'h01);
        `CHK(device_on_o, 1'b1);
        rdc(8'h1f, 8'h00);
        wr(8'h10, 8'h07);
        brightness_code(8'hff, 3'h7);
        wr(8'h11, 8'h00);
        repeat (3)
        begin
            i_model.set_sense(1'b1, 1'b0, 2'b01);
            tick(3);
            i_model.set_sense(1'b0, 1'b1, 2'b01);
            tick(3);
        end
        rdc(8'h1f, 8'h11);
        i_model.set_sense(1'b1, 1'b0, 2'b10);
        tick(PER + 5);
        i_model.set_sense(1'b0, 1'b1, 2'b00);
        rdc(8'h1f, 8'h11);
        wr(8'h1e, 8'h01);
        i_model.set_sense(1'b1, 1'b0, 2'b00);
        tick(PER + 5);
        `CHK(device_on_o, 1'b0);
        i_model.set_sense(1'b0, 1'b1, 2'b00);
        wr(8'h10, 8'h07);
        `CHK(device_on_o, 1'b0);
        rdc(8'h1f, 8'h01);
        wr(8'h10, 8'h07);
        `CHK(device_on_o, 1'b1);
        $display("test fault done");
        finish_test();
    end

    // Watchdog
    initial
    begin
        repeat (4000) @(posedge clk_sys_i);
        failures++;
        finish_test();
    end
endmodule
